// File: common/mgc_map.svh
// register indices, field positions, reset values and counts of the block
`ifndef MGC_MAP_SVH
`define MGC_MAP_SVH

// register indices; byte address is four times the index
`define MGC_IDX_WATERMARK 10'h0B4
`define MGC_IDX_CHIP_ID 10'h0C0
`define MGC_IDX_GLOBAL_CTRL 10'h0C6
`define MGC_IDX_IND_CMD 10'h0C8
`define MGC_IDX_IND_DATA_LO 10'h0D0
`define MGC_IDX_IND_DATA_HI 10'h0D2
`define MGC_IDX_PWR_CTRL 10'h0D4
`define MGC_IDX_IRQ_STATUS 10'h0E8
`define MGC_IDX_IRQ_MASK 10'h0EA

// reset values
`define MGC_RST_WATERMARK 12'h040
`define MGC_RST_GLOBAL_CTRL 16'h0835
`define MGC_RST_IND_CMD 16'h0000
`define MGC_RST_IND_DATA 16'h0000
`define MGC_RST_PWR_CTRL 16'h0000

// field positions
`define MGC_GC_LED_SEL 9
`define MGC_CMD_READ_EN 12
`define MGC_CMD_TBL_HI 11
`define MGC_CMD_TBL_LO 10
`define MGC_CMD_ADDR_HI 4
`define MGC_TBL_STATS 2'h3
`define MGC_PC_DELAY_EN 14
`define MGC_PC_POLARITY 12
`define MGC_PC_AUTO_WAKE 7
// writable bits of the power-event control word (5-2 and 15 read zero)
`define MGC_PC_WR_MASK 16'h7FC3

// interrupt status bits
`define MGC_IRQ_IND_DONE 0
`define MGC_IRQ_PWR_EVT 1
`define MGC_IRQ_W 2

// axi responses
`define MGC_RESP_OKAY 2'h0
`define MGC_RESP_SLVERR 2'h2

`endif

// File: common/mgc_pkg.sv
// types shared by the global configuration register block
package mgc_pkg;

  // decoded fields of the indirect access command
  typedef struct packed {
    logic read_en;
    logic [1:0] table_sel;
    logic [4:0] addr;
  } mgc_cmd_s;

  // decoded fields of the power-event control word
  typedef struct packed {
    logic delay_en;
    logic polarity;
    logic auto_wake;
  } mgc_pwr_s;

  // port led drive pair
  typedef struct packed {
    logic led_one;
    logic led_zero;
  } mgc_led_s;

endpackage

// File: rtl/mgc_global_regs.sv
// global configuration registers with indirect statistics counter access
//
// Notes on behaviour
// - 12-bit rx overrun watermark in double words, resets to 0x0040.
// - identification register: family 15-8, chip 7-4, revision 3-1 read-only; bit 0 writable.
// - global control bit 9 picks led functions; 1 activity/link, 0 alternate.
// - a write to the indirect command register launches an operation only with bit 12 set and table 11.
// - command bit 12 set reads counter into data, then clears it.
// - table select 11 addresses counters; other codes are reserved for host.
// - command bits 4-0 select one of 32 counters.
// - data low word shows bits 15-0 of the value read.
// - data high word shows bits 31-16 of the value read.
// - delay bit 14 set holds power event until clocks ready.
// - delay bit 0 drives power event at once on trigger.
// - delay setting acts only while auto wake-up bit 7 is set.
// - bit 7 enables automatic wake from energy-detect low power.
// - bit 12 sets power event polarity: 1 high, 0 low.
`timescale 1ns/100ps
`include "mgc_map.svh"

module mgc_global_regs
  import mgc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int CNT_NUM = 32,
  parameter int CNT_W = 32,
  // identification codes; values are arbitrary
  parameter logic [7:0] FAMILY_CODE = 8'h5A,
  parameter logic [3:0] CHIP_CODE = 4'h3,
  parameter logic [2:0] REVISION_CODE = 3'h2
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // statistics counter increments, one pulse per counter
  input wire logic [CNT_NUM-1:0] stat_inc,
  // port status for led indication
  input wire logic link_up,
  input wire logic activity,
  input wire logic speed_100,
  // wake-up side
  input wire logic wake_event,
  input wire logic clocks_ready,
  // configuration outputs
  output logic [11:0] rx_overrun_watermark,
  output logic auto_wake_enable,
  // indicators and interrupt
  output logic port_led_one,
  output logic port_led_zero,
  output logic power_event_output,
  output logic irq
);

  // ==========================================================================
  // helpers
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [9:0] idx);
    addr_hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    addr_known = addr_hit(a, `MGC_IDX_WATERMARK)
      | addr_hit(a, `MGC_IDX_CHIP_ID)
      | addr_hit(a, `MGC_IDX_GLOBAL_CTRL)
      | addr_hit(a, `MGC_IDX_IND_CMD)
      | addr_hit(a, `MGC_IDX_IND_DATA_LO)
      | addr_hit(a, `MGC_IDX_IND_DATA_HI)
      | addr_hit(a, `MGC_IDX_PWR_CTRL)
      | addr_hit(a, `MGC_IDX_IRQ_STATUS)
      | addr_hit(a, `MGC_IDX_IRQ_MASK);
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] st);
    merge16[7:0] = st[0] ? wd[7:0] : old[7:0];
    merge16[15:8] = st[1] ? wd[15:8] : old[15:8];
  endfunction

  // ==========================================================================
  // register storage
  logic [11:0] watermark;
  logic chip_spare;
  logic [15:0] global_control;
  logic [15:0] indirect_access_command;
  logic [15:0] indirect_data_low;
  logic [15:0] indirect_data_high;
  logic [15:0] power_event_control;
  logic [`MGC_IRQ_W-1:0] irq_status;
  logic [`MGC_IRQ_W-1:0] irq_mask;
  logic [CNT_W-1:0] stat_cnt [CNT_NUM];
  logic pwr_active_q;

  // ==========================================================================
  // bus handshakes
  wire logic wr_fire = s_axi_awready & s_axi_awvalid
    & s_axi_wready & s_axi_wvalid;
  wire logic rd_fire = s_axi_arready & s_axi_arvalid;
  wire logic wr_start = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
    & ~s_axi_bvalid;
  wire logic rd_start = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;

  wire logic wr_wm = wr_fire & addr_hit(s_axi_awaddr, `MGC_IDX_WATERMARK);
  wire logic wr_id = wr_fire & addr_hit(s_axi_awaddr, `MGC_IDX_CHIP_ID);
  wire logic wr_gc = wr_fire & addr_hit(s_axi_awaddr, `MGC_IDX_GLOBAL_CTRL);
  wire logic wr_cmd = wr_fire & addr_hit(s_axi_awaddr, `MGC_IDX_IND_CMD);
  wire logic wr_dlo = wr_fire & addr_hit(s_axi_awaddr, `MGC_IDX_IND_DATA_LO);
  wire logic wr_dhi = wr_fire & addr_hit(s_axi_awaddr, `MGC_IDX_IND_DATA_HI);
  wire logic wr_pc = wr_fire & addr_hit(s_axi_awaddr, `MGC_IDX_PWR_CTRL);
  wire logic wr_msk = wr_fire & addr_hit(s_axi_awaddr, `MGC_IDX_IRQ_MASK);
  wire logic rd_sts = rd_fire & addr_hit(s_axi_araddr, `MGC_IDX_IRQ_STATUS);

  // ==========================================================================
  // indirect command decode
  wire logic [15:0] cmd_word = merge16(indirect_access_command, s_axi_wdata,
                                       s_axi_wstrb);
  wire mgc_cmd_s cmd = '{read_en: cmd_word[`MGC_CMD_READ_EN],
                         table_sel: cmd_word[`MGC_CMD_TBL_HI:`MGC_CMD_TBL_LO],
                         addr: cmd_word[`MGC_CMD_ADDR_HI:0]};
  // reserved table codes do nothing; only the counter table is served
  wire logic ind_read = wr_cmd & cmd.read_en
    & (cmd.table_sel == `MGC_TBL_STATS);
  wire logic [CNT_W-1:0] sel_cnt = stat_cnt[cmd.addr];

  // ==========================================================================
  // power event
  wire mgc_pwr_s pwr = '{delay_en: power_event_control[`MGC_PC_DELAY_EN],
                         polarity: power_event_control[`MGC_PC_POLARITY],
                         auto_wake: power_event_control[`MGC_PC_AUTO_WAKE]};
  // holdoff applies only when both delay and auto wake are set
  wire logic pwr_hold = pwr.delay_en & pwr.auto_wake;
  wire logic pwr_active = wake_event
    & (~pwr_hold | clocks_ready);
  wire logic pwr_level = pwr.polarity ? pwr_active : ~pwr_active;

  // ==========================================================================
  // led selection
  wire mgc_led_s led_next = global_control[`MGC_GC_LED_SEL]
    ? mgc_led_s'{led_one: activity, led_zero: link_up}
    : mgc_led_s'{led_one: speed_100, led_zero: link_up & activity};

  // ==========================================================================
  // interrupt events
  wire logic [`MGC_IRQ_W-1:0] irq_set = {pwr_active & ~pwr_active_q,
                                         ind_read};
  wire logic [`MGC_IRQ_W-1:0] irq_keep = rd_sts ? '0 : irq_status;

  // ==========================================================================
  // read mux
  logic [15:0] rd_word;
  always_comb
  begin
    rd_word = 16'h0000;
    if (addr_hit(s_axi_araddr, `MGC_IDX_WATERMARK))
      rd_word = {4'h0, watermark};
    else if (addr_hit(s_axi_araddr, `MGC_IDX_CHIP_ID))
      rd_word = {FAMILY_CODE, CHIP_CODE, REVISION_CODE, chip_spare};
    else if (addr_hit(s_axi_araddr, `MGC_IDX_GLOBAL_CTRL))
      rd_word = global_control;
    else if (addr_hit(s_axi_araddr, `MGC_IDX_IND_CMD))
      rd_word = indirect_access_command;
    else if (addr_hit(s_axi_araddr, `MGC_IDX_IND_DATA_LO))
      rd_word = indirect_data_low;
    else if (addr_hit(s_axi_araddr, `MGC_IDX_IND_DATA_HI))
      rd_word = indirect_data_high;
    else if (addr_hit(s_axi_araddr, `MGC_IDX_PWR_CTRL))
      rd_word = power_event_control;
    else if (addr_hit(s_axi_araddr, `MGC_IDX_IRQ_STATUS))
      rd_word = {14'h0000, irq_status};
    else if (addr_hit(s_axi_araddr, `MGC_IDX_IRQ_MASK))
      rd_word = {14'h0000, irq_mask};
  end

  // ==========================================================================
  // axi write channel
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MGC_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= wr_start;
      s_axi_wready <= wr_start;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(s_axi_awaddr) ? `MGC_RESP_OKAY
                                                 : `MGC_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // axi read channel
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MGC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= rd_start;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rd_word};
        s_axi_rresp <= addr_known(s_axi_araddr) ? `MGC_RESP_OKAY
                                                 : `MGC_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // configuration registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      watermark <= `MGC_RST_WATERMARK;
      chip_spare <= 1'b0;
      global_control <= `MGC_RST_GLOBAL_CTRL;
      indirect_access_command <= `MGC_RST_IND_CMD;
      power_event_control <= `MGC_RST_PWR_CTRL;
      irq_mask <= '0;
    end
    else
    begin
      if (wr_wm)
        watermark <= 12'(merge16({4'h0, watermark}, s_axi_wdata,
                                 s_axi_wstrb));
      if (wr_id && s_axi_wstrb[0])
        chip_spare <= s_axi_wdata[0];
      if (wr_gc)
        global_control <= merge16(global_control, s_axi_wdata,
                                  s_axi_wstrb);
      if (wr_cmd)
        indirect_access_command <= cmd_word;
      if (wr_pc)
        power_event_control <= merge16(power_event_control, s_axi_wdata,
                                       s_axi_wstrb) & `MGC_PC_WR_MASK;
      if (wr_msk && s_axi_wstrb[0])
        irq_mask <= s_axi_wdata[`MGC_IRQ_W-1:0];
    end
  end

  // ==========================================================================
  // indirect data words; a counter read overrides a host write
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      indirect_data_low <= `MGC_RST_IND_DATA;
      indirect_data_high <= `MGC_RST_IND_DATA;
    end
    else if (ind_read)
    begin
      indirect_data_low <= sel_cnt[15:0];
      indirect_data_high <= sel_cnt[31:16];
    end
    else
    begin
      if (wr_dlo)
        indirect_data_low <= merge16(indirect_data_low, s_axi_wdata,
                                     s_axi_wstrb);
      if (wr_dhi)
        indirect_data_high <= merge16(indirect_data_high, s_axi_wdata,
                                      s_axi_wstrb);
    end
  end

  // ==========================================================================
  // statistics counters; an increment in the clearing cycle is kept
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < CNT_NUM; i++)
        stat_cnt[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < CNT_NUM; i++)
      begin
        if (ind_read && cmd.addr == 5'(i))
          stat_cnt[i] <= CNT_W'(stat_inc[i]);
        else if (stat_inc[i])
          stat_cnt[i] <= stat_cnt[i] + CNT_W'(1);
      end
    end
  end

  // ==========================================================================
  // interrupt status, clear on read, set wins over the clear
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_status <= '0;
      pwr_active_q <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= irq_keep | irq_set;
      pwr_active_q <= pwr_active;
      irq <= |((irq_keep | irq_set) & irq_mask);
    end
  end

  // ==========================================================================
  // registered outputs
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_overrun_watermark <= `MGC_RST_WATERMARK;
      auto_wake_enable <= 1'b0;
      port_led_one <= 1'b0;
      port_led_zero <= 1'b0;
      // reset polarity bit is 0, so the idle level is high
      power_event_output <= 1'b1;
    end
    else
    begin
      rx_overrun_watermark <= watermark;
      auto_wake_enable <= pwr.auto_wake;
      port_led_one <= led_next.led_one;
      port_led_zero <= led_next.led_zero;
      power_event_output <= pwr_level;
    end
  end

endmodule

// File: tb/mgc_port_model.sv
// port-side model: counter increments, port status and wake inputs
`timescale 1ns/100ps

module mgc_port_model
(
  // clock
  input wire logic sys_clk,
  // counter increments
  output logic [31:0] stat_inc,
  // port status
  output logic link_up,
  output logic activity,
  output logic speed_100,
  // wake side
  output logic wake_event,
  output logic clocks_ready
);
  initial
  begin
    stat_inc = '0;
    {link_up, activity, speed_100} = 3'b000;
    {wake_event, clocks_ready} = 2'b00;
  end

  // =====
  // stimulus tasks, entered right after an edge
  // holding one line high n edges gives exactly n counts
  task automatic pulse(input int idx, input int n);
    stat_inc <= 32'h0000_0001 << idx;
    repeat (n) @(posedge sys_clk);
    stat_inc <= '0;
    // one idle edge so a following call never retargets in the same step
    @(posedge sys_clk);
  endtask

  task automatic set_port(input logic l, input logic a, input logic s);
    link_up <= l;
    activity <= a;
    speed_100 <= s;
  endtask

  task automatic set_wake(input logic w, input logic c);
    wake_event <= w;
    clocks_ready <= c;
  endtask
endmodule

// File: tb/mgc_regs_checker.sv
// concurrent checks on the global register block ports
`timescale 1ns/100ps
`include "mgc_map.svh"

module mgc_regs_checker
#(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port side
  input wire logic link_up,
  input wire logic wake_event,
  input wire logic clocks_ready,
  input wire logic [11:0] rx_overrun_watermark,
  input wire logic auto_wake_enable,
  input wire logic port_led_zero,
  input wire logic power_event_output
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // =====
  // bus steps
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  sequence s_wr_to(logic [9:0] idx);
    s_wr_take ##0 (s_axi_awaddr == {idx, 2'b00}) && &s_axi_wstrb[1:0];
  endsequence

  // =====
  // assertions
  a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write response missing");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data missing");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ready_pair: assert property (s_axi_awready |-> s_axi_wready)
    else $error("address and data ready apart");
  // register lands at the take edge, the output flop one edge later
  a_wmark_write: assert property (s_wr_to(`MGC_IDX_WATERMARK)
    |=> ##1 rx_overrun_watermark == $past(s_axi_wdata[11:0], 2))
    else $error("watermark not written");
  a_wmark_still: assert property ($changed(rx_overrun_watermark)
    |-> $past(s_axi_awvalid && s_axi_awready, 2))
    else $error("watermark changed without write");
  a_auto_wake: assert property (s_wr_to(`MGC_IDX_PWR_CTRL)
    |=> ##1 auto_wake_enable == $past(s_axi_wdata[7], 2))
    else $error("auto wake bit not written");
  a_led_link: assert property (!link_up |=> !port_led_zero)
    else $error("led lit without link");
  // with the delay inert or clocks ready the event shows one cycle later
  a_pwr_prompt: assert property ($rose(wake_event)
    && (clocks_ready || !auto_wake_enable)
    |=> power_event_output != $past(power_event_output))
    else $error("power event not prompt");
endmodule

// File: tb/tb.sv
// self-checking bench for the global configuration register block
`timescale 1ns/100ps
`include "mgc_map.svh"

module tb;
  // arbitrary identification codes
  localparam logic [7:0] FAM = 8'h5A;
  localparam logic [3:0] CHIP = 4'h3;
  localparam logic [2:0] REV = 3'h2;
  logic sys_clk, resetn;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, stat_inc, rd_val;
  logic [1:0] bresp, rresp, wr_resp, rd_resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic link_up, activity, speed_100, wake_event, clocks_ready;
  logic [11:0] wmark;
  logic auto_wake, led_one, led_zero, pwr_out, irq;
  int mismatches, comparisons;
  logic [15:0] pcfg [5] = '{16'h1000, 16'h5080, 16'h5080, 16'h5000, 16'h0};
  logic pclk [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
  logic pexp [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  mgc_global_regs #(.FAMILY_CODE(FAM), .CHIP_CODE(CHIP),
    .REVISION_CODE(REV)) uut (.sys_clk(sys_clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .stat_inc(stat_inc), .link_up(link_up),
    .activity(activity), .speed_100(speed_100), .wake_event(wake_event),
    .clocks_ready(clocks_ready), .rx_overrun_watermark(wmark),
    .auto_wake_enable(auto_wake), .port_led_one(led_one),
    .port_led_zero(led_zero), .power_event_output(pwr_out), .irq(irq));

  mgc_port_model pm (.sys_clk(sys_clk), .stat_inc(stat_inc),
    .link_up(link_up), .activity(activity), .speed_100(speed_100),
    .wake_event(wake_event), .clocks_ready(clocks_ready));

  // =====
  // bus tasks and comparison
  task automatic chk(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge sys_clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    wr_resp = bresp;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [9:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_val = rdata;
    rd_resp = rresp;
    @(posedge sys_clk);
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [15:0] exp);
    rd(idx);
    chk($sformatf("register %h", idx), rd_val, {16'h0000, exp});
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // =====
  // clock, watchdog and tests
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // the tests need about two hundred cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = '0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rdc(`MGC_IDX_WATERMARK, 16'h0040);
    rdc(`MGC_IDX_GLOBAL_CTRL, 16'h0835);
    rdc(`MGC_IDX_IND_DATA_LO, 16'h0000);
    rdc(`MGC_IDX_IND_DATA_HI, 16'h0000);
    rdc(`MGC_IDX_CHIP_ID, {FAM, CHIP, REV, 1'b0});
    wr(`MGC_IDX_CHIP_ID, 16'hFFFF);
    rdc(`MGC_IDX_CHIP_ID, {FAM, CHIP, REV, 1'b1});
    wr(`MGC_IDX_WATERMARK, 16'h0123);
    rdc(`MGC_IDX_WATERMARK, 16'h0123);
    chk("watermark port", wmark, 12'h123);
    rd(10'h0B6);
    chk("unmapped read data", rd_val, 32'h0000_0000);
    chk("unmapped read resp", rd_resp, `MGC_RESP_SLVERR);
    wr(10'h0B6, 16'hFFFF);
    chk("unmapped write", wr_resp, `MGC_RESP_SLVERR);
    $display("test registers done");
    pm.pulse(5, 3);
    pm.pulse(31, 7);
    wr(`MGC_IDX_IRQ_MASK, 16'h0003);
    wr(`MGC_IDX_IND_CMD, 16'h1C05);
    rdc(`MGC_IDX_IND_DATA_LO, 16'h0003);
    rdc(`MGC_IDX_IND_DATA_HI, 16'h0000);
    chk("irq raised", irq, 1'b1);
    rdc(`MGC_IDX_IRQ_STATUS, 16'h0001);
    chk("irq cleared", irq, 1'b0);
    for (int t = 0; t < 4; t++)
    begin
      wr(`MGC_IDX_IND_CMD, {3'b000, 1'b1, t[1:0], 5'h00, 5'h1F});
      rdc(`MGC_IDX_IND_DATA_LO, (t == 3) ? 16'h0007 : 16'h0003);
    end
    pm.pulse(5, 2);
    wr(`MGC_IDX_IND_CMD, 16'h0C05);
    rdc(`MGC_IDX_IND_DATA_LO, 16'h0007);
    rdc(`MGC_IDX_IND_CMD, 16'h0C05);
    wr(`MGC_IDX_IRQ_MASK, 16'h0000);
    wr(`MGC_IDX_IND_CMD, 16'h1C05);
    rdc(`MGC_IDX_IND_DATA_LO, 16'h0002);
    chk("irq masked", irq, 1'b0);
    rdc(`MGC_IDX_IRQ_STATUS, 16'h0001);
    wr(`MGC_IDX_IND_CMD, 16'h1C05);
    rdc(`MGC_IDX_IND_DATA_LO, 16'h0000);
    $display("test counters done");
    pm.set_port(1'b1, 1'b0, 1'b1);
    wr(`MGC_IDX_GLOBAL_CTRL, 16'h0A35);
    repeat (3) @(posedge sys_clk);
    chk("leds select one", {led_one, led_zero}, 2'b01);
    wr(`MGC_IDX_GLOBAL_CTRL, 16'h0835);
    repeat (3) @(posedge sys_clk);
    chk("leds select zero", {led_one, led_zero}, 2'b10);
    $display("test leds done");
    for (int i = 0; i < 5; i++)
    begin
      pm.set_wake(1'b0, pclk[i]);
      wr(`MGC_IDX_PWR_CTRL, pcfg[i]);
      repeat (3) @(posedge sys_clk);
      chk("power idle", pwr_out, !pcfg[i][12]);
      chk("auto wake", auto_wake, pcfg[i][7]);
      pm.set_wake(1'b1, pclk[i]);
      repeat (3) @(posedge sys_clk);
      chk("power event", pwr_out, pexp[i]);
    end
    // bit 0 is still set by the last counter read of the counter test
    rdc(`MGC_IDX_IRQ_STATUS, 16'h0003);
    $display("test power event done");
    report_and_stop();
  end
endmodule

bind mgc_global_regs mgc_regs_checker #(.ADDR_W(ADDR_W)) chk_i (
  .sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .link_up(link_up), .wake_event(wake_event), .clocks_ready(clocks_ready),
  .rx_overrun_watermark(rx_overrun_watermark),
  .auto_wake_enable(auto_wake_enable), .port_led_zero(port_led_zero),
  .power_event_output(power_event_output));
